// file: logic/usp_regs.svh
`ifndef USP_REGS_SVH
`define USP_REGS_SVH

// Register index and byte address of the pin control and status word
`define USP_CTRL_INDEX 12'h262
`define USP_CTRL_ADDR 12'h988

// Field positions inside the 16-bit word
`define USP_LEVEL1_BIT 13
`define USP_SECOND_PIN_CONDITION_SELECT_HI 12
`define USP_SECOND_PIN_CONDITION_SELECT_LO 10
`define USP_DRV1_HI 9
`define USP_DRV1_LO 8
`define USP_LEVEL0_BIT 5
`define USP_FIRST_PIN_CONDITION_SELECT_HI 4
`define USP_FIRST_PIN_CONDITION_SELECT_LO 2
`define USP_DRV0_HI 1
`define USP_DRV0_LO 0

// Reset values
`define USP_SEL_RESET 3'h0
`define USP_DRV_RESET 2'h2

// Drive type codes
`define USP_DRV_OPEN_DRAIN 2'h1
`define USP_DRV_ACTIVE 2'h2

// Condition select codes
`define USP_SEL_SUSP_RST 3'h0
`define USP_SEL_SUSP_HI 3'h1
`define USP_SEL_POWER_HI 3'h2
`define USP_SEL_RST_HI 3'h3
`define USP_SEL_SUSP_RST_ALT 3'h4
`define USP_SEL_SUSP_LO 3'h5
`define USP_SEL_POWER_LO 3'h6
`define USP_SEL_RST_LO 3'h7

// Largest bus current, in mA, that still counts as a low power device
`define USP_LOW_POWER_MAX_MA 10'h064

`endif

// file: logic/usp_pkg.sv
package usp_pkg;

  // Condition inputs from the protocol engine
  typedef struct packed {
    logic suspended;
    logic busReset;
    logic configured;
  } usp_cond_t;

  // Pin drive towards the pads, bit 0 is the first pin, bit 1 the second
  typedef struct packed {
    logic [1:0] level;
    logic [1:0] enN;
  } usp_pin_drive_t;

  // Whole state of the top module
  typedef struct packed {
    logic [2:0] second_pin_condition_select;
    logic [1:0] drv1;
    logic [2:0] first_pin_condition_select;
    logic [1:0] drv0;
    logic [1:0] pinLevel;
    usp_pin_drive_t drive;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } usp_state_t;

endpackage : usp_pkg

// file: logic/usp_cond_decode.sv
`timescale 1ns/1ns
`include "usp_regs.svh"

module usp_cond_decode #(
  parameter bit FIRST_PIN = 1'b1
) (
  input wire logic [2:0] sel, // Condition select code
  input wire logic suspended, // Device suspended
  input wire logic busReset, // Bus reset in progress
  input wire logic notConfigured, // Not yet configured
  input wire logic lowPower, // Low power classification
  output logic level // Wanted pin level
);

  logic cond;
  logic activeHigh;

  // Which condition the code watches
  always_comb
  begin
    cond = 1'b0;
    case (sel)
      `USP_SEL_SUSP_RST, `USP_SEL_SUSP_RST_ALT: cond = suspended | busReset;
      `USP_SEL_SUSP_HI, `USP_SEL_SUSP_LO: cond = suspended;
      `USP_SEL_POWER_HI, `USP_SEL_POWER_LO:
        cond = lowPower ? suspended : (suspended | notConfigured);
      `USP_SEL_RST_HI, `USP_SEL_RST_LO: cond = busReset;
      default: cond = 1'b0;
    endcase
  end

  // Polarity: the upper half of the codes asserts low, except that the
  // shared code 100 keeps the polarity of code 000 for each pin
  always_comb
  begin
    if (FIRST_PIN)
    begin
      activeHigh = !sel[2] && (sel != `USP_SEL_SUSP_RST);
    end
    else
    begin
      activeHigh = !sel[2] || (sel == `USP_SEL_SUSP_RST_ALT);
    end
  end

  // Idle level is the opposite of the asserted level
  assign level = activeHigh ? cond : !cond;

endmodule : usp_cond_decode

// file: logic/usp_status_pins.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`include "usp_regs.svh"

module usp_status_pins #(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk, // Core clock, 10 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input usp_pkg::usp_cond_t usbCond, // Device condition flags
  input wire logic [9:0] maxCurrentMa, // Configured bus current in mA
  input wire logic [1:0] pinIn, // Level seen on the two pins
  output usp_pkg::usp_pin_drive_t pinDrive // Level and enable towards the pins
);

  usp_pkg::usp_state_t stateQ;
  usp_pkg::usp_state_t stateD;
  logic lowPower;
  logic addrHit;
  logic accessCycle;
  logic wrAccept;
  logic [1:0] wantLevel;
  logic [1:0] openDrain;
  logic [2:0] selArr [2];
  logic [15:0] regWord;

  // Power class from the configured current
  assign lowPower = maxCurrentMa <= `USP_LOW_POWER_MAX_MA;

  // Full address compare, so misaligned or other words are unmapped
  assign addrHit = paddr == ADDR_W'(`USP_CTRL_ADDR);

  // First access cycle starts the answer; the next one with ready high completes
  assign accessCycle = psel && penable && !stateQ.pready;
  assign wrAccept = psel && penable && stateQ.pready && pwrite && addrHit;

  // Register image; reserved bits read as zero
  assign regWord = {2'h0, stateQ.pinLevel[1], stateQ.second_pin_condition_select, stateQ.drv1,
                    2'h0, stateQ.pinLevel[0], stateQ.first_pin_condition_select, stateQ.drv0};

  assign selArr[0] = stateQ.first_pin_condition_select;
  assign selArr[1] = stateQ.second_pin_condition_select;

  // One condition decoder per pin; only the first pin flips code 000
  for (genvar i = 0; i < 2; i++)
  begin : g_pin
    usp_cond_decode #(
      .FIRST_PIN(i == 0)
    ) u_decode (
      .sel(selArr[i]),
      .suspended(usbCond.suspended),
      .busReset(usbCond.busReset),
      .notConfigured(!usbCond.configured),
      .lowPower(lowPower),
      .level(wantLevel[i])
    );
    // Codes 00 and 11 are invalid; they fall back to active drive
    assign openDrain[i] = (i == 0) ? (stateQ.drv0 == `USP_DRV_OPEN_DRAIN)
                                   : (stateQ.drv1 == `USP_DRV_OPEN_DRAIN);
  end

  // Next state
  always_comb
  begin
    stateD = stateQ;
    // Pin levels are sampled every cycle; writes never reach them
    stateD.pinLevel = pinIn;
    // Open drain releases the pin for a high level, active drive always drives
    for (int i = 0; i < 2; i++)
    begin
      stateD.drive.level[i] = wantLevel[i];
      stateD.drive.enN[i] = openDrain[i] && wantLevel[i];
    end
    // APB answer one cycle into the access phase
    stateD.pready = accessCycle;
    stateD.pslverr = accessCycle && !addrHit;
    stateD.prdata = 32'h0000_0000;
    if (accessCycle && !pwrite && addrHit)
    begin
      stateD.prdata = {16'h0000, regWord};
    end
    // Only select and drive fields take write data; reserved and level bits drop
    if (wrAccept)
    begin
      stateD.second_pin_condition_select = pwdata[`USP_SECOND_PIN_CONDITION_SELECT_HI:`USP_SECOND_PIN_CONDITION_SELECT_LO];
      stateD.drv1 = pwdata[`USP_DRV1_HI:`USP_DRV1_LO];
      stateD.first_pin_condition_select = pwdata[`USP_FIRST_PIN_CONDITION_SELECT_HI:`USP_FIRST_PIN_CONDITION_SELECT_LO];
      stateD.drv0 = pwdata[`USP_DRV0_HI:`USP_DRV0_LO];
    end
  end

  // State register; reset drives both pins actively at code 000 idle levels
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateQ.second_pin_condition_select <= `USP_SEL_RESET;
      stateQ.drv1 <= `USP_DRV_RESET;
      stateQ.first_pin_condition_select <= `USP_SEL_RESET;
      stateQ.drv0 <= `USP_DRV_RESET;
      stateQ.pinLevel <= 2'h0;
      stateQ.drive.level <= 2'h1;
      stateQ.drive.enN <= 2'h0;
      stateQ.prdata <= 32'h0000_0000;
      stateQ.pready <= 1'b0;
      stateQ.pslverr <= 1'b0;
    end
    else
    begin
      stateQ <= stateD;
    end
  end

  // Outputs straight from the state register
  assign prdata = stateQ.prdata;
  assign pready = stateQ.pready;
  assign pslverr = stateQ.pslverr;
  assign pinDrive = stateQ.drive;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable && !pready;
  endsequence

  sequence s_done;
    psel && penable && pready;
  endsequence

  // A setup followed by an access is answered one cycle later
  a_apb_answer: assert property (s_setup ##1 s_access |=> pready)
    else $error("ready did not follow the access phase");

  // Ready stands for exactly one cycle
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");

  // A completed write lands in both select fields
  a_write_sel: assert property ((s_done and (pwrite && addrHit)) |=>
      stateQ.second_pin_condition_select == $past(pwdata[12:10]) && stateQ.first_pin_condition_select == $past(pwdata[4:2]))
    else $error("select fields not taken from write data");

  // Select fields change only by a completed write
  a_sel_stable: assert property (!wrAccept |=> $stable(stateQ.first_pin_condition_select) && $stable(stateQ.second_pin_condition_select))
    else $error("select field changed without a write");

  // Level bits follow the pins whatever is written
  a_level_track: assert property (1'b1 |=> stateQ.pinLevel == $past(pinIn))
    else $error("pin level bits do not follow the pins");

  // Read data bit 13 shows the second pin level of the cycle before
  a_read_lvl1: assert property ((s_done and (!pwrite && addrHit)) |->
      prdata[13] == $past(stateQ.pinLevel[1]))
    else $error("bit 13 does not return the second pin level");

  // Read data bit 5 shows the first pin level of the cycle before
  a_read_lvl0: assert property ((s_done and (!pwrite && addrHit)) |->
      prdata[5] == $past(stateQ.pinLevel[0]))
    else $error("bit 5 does not return the first pin level");

  // Unmapped access answers with an error and zero data
  a_unmapped_err: assert property ((s_access and !addrHit) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");

  // Second pin code 000 asserts high on suspend or reset
  a_pin2_both: assert property ((stateQ.second_pin_condition_select == 3'h0 && (usbCond.suspended || usbCond.busReset))
      |=> pinDrive.level[1])
    else $error("second pin not high for code 000");

  // Second pin code 011 stays low without bus reset
  a_pin2_rst: assert property ((stateQ.second_pin_condition_select == 3'h3 && !usbCond.busReset) |=> !pinDrive.level[1])
    else $error("second pin not idle low for code 011");

  // Second pin code 010 at high power asserts while unconfigured
  a_pin2_power: assert property ((stateQ.second_pin_condition_select == 3'h2 && maxCurrentMa > 10'd100
      && !usbCond.configured) |=> pinDrive.level[1])
    else $error("second pin ignores unconfigured at high power");

  // Low power ignores the configuration state
  a_pin2_lowpwr: assert property ((stateQ.second_pin_condition_select == 3'h2 && maxCurrentMa <= 10'd100
      && !usbCond.suspended) |=> !pinDrive.level[1])
    else $error("second pin asserted at low power without suspend");

  // Second pin low polarity codes
  a_pin2_low: assert property ((stateQ.second_pin_condition_select == 3'h5 && usbCond.suspended) ||
      (stateQ.second_pin_condition_select == 3'h7 && usbCond.busReset) |=> !pinDrive.level[1])
    else $error("second pin not low for codes 101 or 111");

  // Second pin code 110 at high power drops low while unconfigured
  a_pin2_pwrlo: assert property ((stateQ.second_pin_condition_select == 3'h6 && maxCurrentMa > 10'd100
      && !usbCond.configured) |=> !pinDrive.level[1])
    else $error("second pin not low for code 110");

  // First pin code 000 and 100 assert low on suspend or reset
  a_pin1_both: assert property (((stateQ.first_pin_condition_select == 3'h0 || stateQ.first_pin_condition_select == 3'h4) &&
      (usbCond.suspended || usbCond.busReset)) |=> !pinDrive.level[0])
    else $error("first pin not low for code 000 or 100");

  // First pin code 001 high only in suspend
  a_pin1_susp: assert property (stateQ.first_pin_condition_select == 3'h1 |=>
      pinDrive.level[0] == $past(usbCond.suspended))
    else $error("first pin does not follow suspend for code 001");

  // First pin code 010 follows the power rule
  a_pin1_power: assert property ((stateQ.first_pin_condition_select == 3'h2 && maxCurrentMa > 10'd100
      && !usbCond.configured) |=> pinDrive.level[0])
    else $error("first pin ignores unconfigured at high power");

  // First pin low polarity codes
  a_pin1_low: assert property ((stateQ.first_pin_condition_select == 3'h5 && usbCond.suspended) ||
      (stateQ.first_pin_condition_select == 3'h7 && usbCond.busReset) |=> !pinDrive.level[0])
    else $error("first pin not low for codes 101 or 111");

  // First pin code 110 with low power ignores configuration
  a_pin1_pwrlo: assert property ((stateQ.first_pin_condition_select == 3'h6 && maxCurrentMa <= 10'd100
      && !usbCond.suspended) |=> pinDrive.level[0])
    else $error("first pin low for code 110 without suspend");

  // Open drain never drives a high level
  a_od_release: assert property ((stateQ.drv1 == 2'h1 && wantLevel[1]) |=> pinDrive.enN[1])
    else $error("second pin driven high in open drain");

  // Active drive keeps the second pin enabled
  a_act_drive2: assert property (stateQ.drv1 == 2'h2 |=> !pinDrive.enN[1])
    else $error("second pin released in active drive");

  // First pin drive type behaves the same way
  a_drive_pin1: assert property ((stateQ.drv0 == 2'h2 || (stateQ.drv0 == 2'h1 && !wantLevel[0]))
      |=> !pinDrive.enN[0])
    else $error("first pin released when it should drive");

  // Open drain releases the first pin for a high level
  a_od_pin1: assert property ((stateQ.drv0 == 2'h1 && wantLevel[0]) |=> pinDrive.enN[0])
    else $error("first pin driven high in open drain");

endmodule : usp_status_pins

// file: sim/usp_board.sv
`timescale 1ns/1ns

// Board side of the two status lines: a pull-up on each line and an optional external
// pull-down, so a released open-drain line never just keeps its last value
module usp_board (
  input usp_pkg::usp_pin_drive_t pinDrive, // Level and enable from the device
  input wire logic [1:0] holdLow, // External circuit pulling a line low
  output logic [1:0] pinIn // Resolved line level back to the device
);
  // Driven line shows the device level, a released one the pull-up or the pull-down
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      pinIn[i] = !pinDrive.enN[i] ? pinDrive.level[i] : !holdLow[i];
    end
  end
endmodule : usp_board

// file: sim/testbench.sv
`timescale 1ns/1ns

module testbench;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s0;
    logic [1:0] d1;
    logic [1:0] d0;
    logic [2:0] c;
    logic [9:0] ma;
    logic [1:0] lv;
  } usp_row_t;

  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] maxCurrentMa;
  logic [1:0] pinIn, holdLow;
  usp_pkg::usp_cond_t usbCond;
  usp_pkg::usp_pin_drive_t pinDrive;
  usp_row_t rows[19];
  int mismatches = 0;
  int nChecks = 0;

  usp_status_pins uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usbCond(usbCond), .maxCurrentMa(maxCurrentMa), .pinIn(pinIn),
    .pinDrive(pinDrive));
  usp_board board (.pinDrive(pinDrive), .holdLow(holdLow), .pinIn(pinIn));

  // Clock, 100 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic reportAndStop;
    $display("mismatches %0d, checks %0d", mismatches, nChecks);
    if (mismatches == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : reportAndStop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk

  // One APB transfer; the answer is awaited under a bound, never assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      mismatches++;
      reportAndStop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  // Reset for six cycles, then the register must read its documented defaults
  task automatic doReset;
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("drive in reset", 32'h00000004, {28'h0000000, pinDrive});
    rst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, 12'h988, 32'h00000000);
    chk("reset value", 32'h00000222, rd);
  endtask : doReset

  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, usbCond, holdLow} = '0;
    maxCurrentMa = 10'h064;
    rows = '{'{3'h0, 3'h0, 2'h2, 2'h2, 3'h4, 10'h064, 2'h2},
      '{3'h0, 3'h0, 2'h2, 2'h2, 3'h2, 10'h064, 2'h2}, '{3'h4, 3'h4, 2'h2, 2'h2, 3'h1, 10'h064, 2'h1},
      '{3'h4, 3'h4, 2'h1, 2'h1, 3'h2, 10'h064, 2'h2}, '{3'h1, 3'h1, 2'h1, 2'h1, 3'h4, 10'h064, 2'h3},
      '{3'h1, 3'h1, 2'h2, 2'h2, 3'h2, 10'h064, 2'h0}, '{3'h3, 3'h3, 2'h2, 2'h2, 3'h2, 10'h064, 2'h3},
      '{3'h3, 3'h3, 2'h2, 2'h2, 3'h4, 10'h064, 2'h0}, '{3'h2, 3'h2, 2'h2, 2'h2, 3'h0, 10'h064, 2'h0},
      '{3'h2, 3'h2, 2'h1, 2'h2, 3'h0, 10'h065, 2'h3}, '{3'h2, 3'h2, 2'h2, 2'h2, 3'h1, 10'h065, 2'h0},
      '{3'h6, 3'h6, 2'h2, 2'h2, 3'h0, 10'h065, 2'h0}, '{3'h6, 3'h6, 2'h2, 2'h1, 3'h0, 10'h064, 2'h3},
      '{3'h5, 3'h5, 2'h2, 2'h2, 3'h4, 10'h064, 2'h0}, '{3'h5, 3'h5, 2'h2, 2'h2, 3'h2, 10'h064, 2'h3},
      '{3'h7, 3'h7, 2'h2, 2'h2, 3'h2, 10'h064, 2'h0}, '{3'h7, 3'h7, 2'h2, 2'h2, 3'h4, 10'h064, 2'h3},
      '{3'h6, 3'h6, 2'h2, 2'h2, 3'h4, 10'h064, 2'h0}, '{3'h1, 3'h3, 2'h2, 2'h2, 3'h4, 10'h064, 2'h2}};
    doReset();
    // Each row: program both selects, apply conditions, check pins and readback
    foreach (rows[i])
    begin
      usbCond <= rows[i].c;
      maxCurrentMa <= rows[i].ma;
      apb(1'b1, 12'h988, {19'h00000, rows[i].s1, rows[i].d1, 3'h0, rows[i].s0, rows[i].d0});
      repeat (2) @(posedge sys_clk);
      chk("pin level", {30'h0, rows[i].lv}, {30'h0, pinDrive.level});
      chk("pin enable", {30'h0, rows[i].d1 == 2'h1 && rows[i].lv[1],
        rows[i].d0 == 2'h1 && rows[i].lv[0]}, {30'h0, pinDrive.enN});
      apb(1'b0, 12'h988, 32'h00000000);
      chk("readback", {18'h00000, rows[i].lv[1], rows[i].s1, rows[i].d1, 2'h0, rows[i].lv[0],
        rows[i].s0, rows[i].d0}, rd);
    end
    // Open drain lines held low outside: level bits show the pad, writes to them do nothing
    usbCond <= 3'h4;
    holdLow <= 2'h3;
    apb(1'b1, 12'h988, 32'h00002525);
    repeat (2) @(posedge sys_clk);
    chk("released lines", 32'h00000003, {30'h0, pinDrive.enN});
    apb(1'b0, 12'h988, 32'h00000000);
    chk("pad levels low", 32'h00000505, rd);
    holdLow <= 2'h1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, 12'h988, 32'h00000000);
    chk("second pad high", 32'h00002505, rd);
    // Unmapped places are refused and leave the register alone
    apb(1'b1, 12'h262, 32'h00000000);
    chk("error at index", 32'h00000001, {31'h0, err});
    apb(1'b1, 12'h98C, 32'h00000000);
    chk("error next word", 32'h00000001, {31'h0, err});
    apb(1'b0, 12'h262, 32'h00000000);
    chk("unmapped read", 32'h00000001, {rd[31:1], err});
    apb(1'b0, 12'h988, 32'h00000000);
    chk("after refusals", 32'h00002505, rd);
    chk("mapped no error", 32'h00000000, {31'h0, err});
    // Quiet conditions again, so the second reset reads the same defaults as the first
    holdLow <= 2'h0;
    usbCond <= 3'h0;
    doReset();
    reportAndStop();
  end
endmodule : testbench
